/* src/hrx_params.svh */
// Offsets, field positions, reset values and sizes for the receive FIFO readout
`ifndef HRX_PARAMS_SVH
`define HRX_PARAMS_SVH
`define HRX_OFF_CTRL 8'hB0
`define HRX_OFF_STATUS 8'hB4
`define HRX_OFF_LATCH 8'hB6
`define HRX_OFF_IRQ_EN 8'hB8
`define HRX_OFF_DATA 8'hBC
`define HRX_OFF_GLB_EN 8'hC0
`define HRX_ADDR_W 8
`define HRX_BIT_AVAIL 0
`define HRX_BIT_EMPTY 1
`define HRX_BIT_FULL 2
`define HRX_BIT_START 3
`define HRX_BIT_END 4
`define HRX_BIT_OVFL 7
`define HRX_EVT_MASK 16'h009D
`define HRX_CTRL_REORDER 3
`define HRX_CTRL_THR_LSB 8
`define HRX_CTRL_RESET 16'h0800
`define HRX_IRQ_EN_RESET 16'h0000
`define HRX_GLB_EN_RESET 16'h0000
`define HRX_CTRL_MASK 16'h1F08
`define HRX_GLB_EN_MASK 16'h001E
`define HRX_FIFO_DEPTH 256
`define HRX_GROUP_BYTES 8
`endif

/* src/hrx_pkg.sv */
// Types shared by the receive FIFO readout
package hrx_pkg;
  typedef enum logic [2:0] {
    HRX_PS_MIDDLE = 3'h0,
    HRX_PS_START = 3'h1,
    HRX_PS_RSV2 = 3'h2,
    HRX_PS_RSV3 = 3'h3,
    HRX_PS_END_GOOD = 3'h4,
    HRX_PS_END_FCS = 3'h5,
    HRX_PS_END_NONINT = 3'h6,
    HRX_PS_END_ABORT = 3'h7
  } hrx_pkt_status_t;
  typedef enum logic [1:0] {
    HRX_BUS_IDLE = 2'h0,
    HRX_BUS_ACK = 2'h1
  } hrx_bus_state_t;
endpackage : hrx_pkg

/* src/hrx_fifo.sv */
// Byte FIFO with packet status tags and fill level
`timescale 1ns/1ns
`include "hrx_params.svh"
module hrx_fifo #(
  parameter int DEPTH = `HRX_FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_push,
  input wire logic [7:0] i_byte,
  input wire hrx_pkg::hrx_pkt_status_t i_status,
  input wire logic i_pop,
  output logic [7:0] o_byte,
  output hrx_pkg::hrx_pkt_status_t o_status,
  output logic [AW:0] o_level,
  output logic o_push_ok
);
  import hrx_pkg::*;
  logic [10:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] level_reg;
  wire full = (level_reg == (AW+1)'(DEPTH));
  wire empty = (level_reg == '0);
  wire do_pop = i_pop && !empty;
  // A pop in the same cycle frees the slot, so a full FIFO still takes the byte
  wire do_push = i_push && (!full || do_pop);
  assign o_push_ok = do_push;
  assign o_level = level_reg;
  assign o_byte = mem[rd_ptr_reg][7:0];
  assign o_status = hrx_pkt_status_t'(mem[rd_ptr_reg][10:8]);
  always_ff @(posedge i_ref_clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= {i_status, i_byte};
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      level_reg <= level_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : hrx_fifo

/* src/hrx_event_latch.sv */
// Sticky event bits, write-one-to-clear, set wins over clear
`timescale 1ns/1ns
module hrx_event_latch #(
  parameter int W = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clear,
  output logic [W-1:0] o_latched
);
  logic [W-1:0] latch_reg;
  logic [W-1:0] latch_next;
  assign latch_next = (latch_reg & ~i_clear) | i_set;
  assign o_latched = latch_reg;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      latch_reg <= '0;
    end else begin
      latch_reg <= latch_next;
    end
  end
endmodule : hrx_event_latch

/* src/hrx_readout.sv */
// Host-side status, event latch, interrupt enable and data readout of the receive FIFO
`timescale 1ns/1ns
`include "hrx_params.svh"
module hrx_readout #(
  parameter int DEPTH = `HRX_FIFO_DEPTH,
  parameter logic [1:0] PORT_INDEX = 2'h0
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [`HRX_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [15:0] i_avs_writedata,
  input wire logic [1:0] i_avs_byteenable,
  output logic [15:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_rx_write,
  input wire logic [7:0] i_rx_byte,
  input wire hrx_pkg::hrx_pkt_status_t i_rx_status,
  output logic o_irq
);
  import hrx_pkg::*;
  localparam int AW = $clog2(DEPTH);

  hrx_bus_state_t bus_state_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] irq_en_reg;
  logic [15:0] glb_en_reg;
  logic [15:0] readdata_reg;
  logic irq_reg;
  logic [7:0] data_byte_reg;
  logic [2:0] data_status_reg;
  logic avail_prev_reg;
  logic full_prev_reg;

  logic [7:0] fifo_byte;
  hrx_pkt_status_t fifo_status;
  logic [AW:0] fifo_level;
  logic push_ok;
  logic [15:0] latched;

  function automatic logic [7:0] bit_reverse(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int k = 0; k < 8; k++) begin
      r[k] = b[7-k];
    end
    return r;
  endfunction : bit_reverse

  // Bus decode
  wire req = i_avs_read || i_avs_write;
  wire take = req && (bus_state_reg == HRX_BUS_IDLE);
  wire rd_take = take && i_avs_read;
  wire wr_take = take && i_avs_write;
  wire hit_ctrl = (i_avs_address == `HRX_OFF_CTRL);
  wire hit_status = (i_avs_address == `HRX_OFF_STATUS);
  wire hit_latch = (i_avs_address == `HRX_OFF_LATCH);
  wire hit_irq_en = (i_avs_address == `HRX_OFF_IRQ_EN);
  wire hit_data = (i_avs_address == `HRX_OFF_DATA);
  wire hit_glb = (i_avs_address == `HRX_OFF_GLB_EN);
  wire [15:0] be_mask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  wire [4:0] thr_groups = ctrl_reg[`HRX_CTRL_THR_LSB +: 5];
  wire [AW+3:0] thr_bytes = (AW+4)'(thr_groups) * (AW+4)'(`HRX_GROUP_BYTES);
  wire live_avail = ((AW+4)'(fifo_level) >= thr_bytes);
  wire live_empty = (fifo_level == '0);
  wire live_full = (fifo_level == (AW+1)'(DEPTH));
  wire [15:0] live_status = {13'h0000, live_full, live_empty, live_avail};

  // pop only on a read of the upper byte of the data register
  wire upper_rd = rd_take && hit_data && i_avs_byteenable[1];
  wire pop = upper_rd && !live_empty;

  // earliest bit in bit 0 unless reordering
  wire [7:0] ordered_byte = ctrl_reg[`HRX_CTRL_REORDER] ? bit_reverse(i_rx_byte) : i_rx_byte;
  // Pop and push in one cycle frees room, so overflow only when truly full
  wire overflow = i_rx_write && live_full && !pop;

  // Event sources
  wire [15:0] evt_set;
  assign evt_set[`HRX_BIT_OVFL] = overflow;
  assign evt_set[`HRX_BIT_END] = push_ok && i_rx_status[2];
  assign evt_set[`HRX_BIT_START] = push_ok && (i_rx_status == HRX_PS_START);
  assign evt_set[`HRX_BIT_FULL] = live_full && !full_prev_reg;
  assign evt_set[`HRX_BIT_AVAIL] = live_avail && !avail_prev_reg;
  assign evt_set[15:8] = 8'h00;
  assign evt_set[6:5] = 2'h0;
  assign evt_set[1] = 1'b0;

  wire [15:0] evt_clr = (wr_take && hit_latch) ?
                        (i_avs_writedata & be_mask & `HRX_EVT_MASK) : 16'h0000;

  // latched and enabled and this port globally enabled
  wire port_en = glb_en_reg[3'(PORT_INDEX) + 3'h1];
  wire irq_next = port_en && |(latched & irq_en_reg & `HRX_EVT_MASK);

  // lower byte shows status of the byte this upper read returns, or on a lower-only read of the byte the next upper read returns
  wire [15:0] data_word = upper_rd ?
      {fifo_byte, 4'h0, fifo_status, !live_empty} :
      {data_byte_reg, 4'h0, (live_empty ? data_status_reg : 3'(fifo_status)), !live_empty};

  wire [15:0] rd_mux =
      hit_ctrl ? ctrl_reg :
      hit_status ? live_status :
      hit_latch ? latched :
      hit_irq_en ? irq_en_reg :
      hit_data ? data_word :
      hit_glb ? glb_en_reg : 16'h0000;

  hrx_fifo #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_push(i_rx_write),
    .i_byte(ordered_byte),
    // packet status tag stored with each byte
    .i_status(i_rx_status),
    .i_pop(pop),
    .o_byte(fifo_byte),
    .o_status(fifo_status),
    .o_level(fifo_level),
    .o_push_ok(push_ok)
  );

  hrx_event_latch #(
    .W(16)
  ) u_latch (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_set(evt_set),
    .i_clear(evt_clr),
    .o_latched(latched)
  );

  // One wait cycle per access, answer on the following edge
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bus_state_reg <= HRX_BUS_IDLE;
    end else begin
      unique case (bus_state_reg)
        HRX_BUS_IDLE: begin
          if (req) begin
            bus_state_reg <= HRX_BUS_ACK;
          end
        end
        HRX_BUS_ACK: begin
          bus_state_reg <= HRX_BUS_IDLE;
        end
        default: begin
          bus_state_reg <= HRX_BUS_IDLE;
        end
      endcase
    end
  end

  // Waitrequest stays high except in the answer cycle
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !take;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      readdata_reg <= 16'h0000;
    end else if (rd_take) begin
      readdata_reg <= rd_mux;
    end
  end
  assign o_avs_readdata = readdata_reg;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_reg <= `HRX_CTRL_RESET;
      irq_en_reg <= `HRX_IRQ_EN_RESET;
      glb_en_reg <= `HRX_GLB_EN_RESET;
    end else if (wr_take) begin
      if (hit_ctrl) begin
        ctrl_reg <= (ctrl_reg & ~be_mask) | (i_avs_writedata & be_mask & `HRX_CTRL_MASK);
      end
      if (hit_irq_en) begin
        irq_en_reg <= (irq_en_reg & ~be_mask) | (i_avs_writedata & be_mask & `HRX_EVT_MASK);
      end
      if (hit_glb) begin
        glb_en_reg <= (glb_en_reg & ~be_mask) | (i_avs_writedata & be_mask & `HRX_GLB_EN_MASK);
      end
    end
  end

  // holding register follows the last upper read
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      data_byte_reg <= 8'h00;
      data_status_reg <= 3'h0;
    end else if (upper_rd) begin
      data_byte_reg <= fifo_byte;
      data_status_reg <= fifo_status;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      avail_prev_reg <= 1'b0;
      full_prev_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      avail_prev_reg <= live_avail;
      full_prev_reg <= live_full;
      irq_reg <= irq_next;
    end
  end
  assign o_irq = irq_reg;
endmodule : hrx_readout

/* verification/hrx_readout_checker.sv */
// Port assertions for the receive FIFO readout
`timescale 1ns/1ns
module hrx_readout_checker
  import hrx_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [15:0] i_avs_writedata,
  input wire logic [1:0] i_avs_byteenable,
  input wire logic [15:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_rx_write,
  input wire logic [7:0] i_rx_byte,
  input wire hrx_pkg::hrx_pkt_status_t i_rx_status,
  input wire logic o_irq
);
  logic [7:0] en_q;
  logic glb_q;
  wire logic take_wr = i_avs_write && o_avs_waitrequest;
  // Shadow of the enables, since only the ports are visible here
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      en_q <= 8'h00;
      glb_q <= 1'b0;
    end else if (take_wr && i_avs_address == 8'hB8) begin
      en_q <= i_avs_writedata[7:0];
    end else if (take_wr && i_avs_address == 8'hC0) begin
      glb_q <= i_avs_writedata[1];
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  chk_wait_pulse: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  chk_req_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("request not answered");
  chk_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest
    && i_avs_address == 8'hB2 |-> o_avs_readdata == 16'h0000) else $error("unmapped read");
  chk_glb_gate: assert property (!glb_q [*3] |-> !o_irq)
    else $error("irq with port disabled");
  chk_en_gate: assert property ((en_q == 8'h00) [*3] |-> !o_irq)
    else $error("irq with events disabled");
  chk_start_irq: assert property (i_rx_write && i_rx_status == HRX_PS_START
    && en_q[3] && glb_q |-> ##[1:3] o_irq) else $error("start event lost");
  chk_end_irq: assert property (i_rx_write && i_rx_status[2] && en_q[4]
    && glb_q |-> ##[1:3] o_irq) else $error("end event lost");
  chk_zero_keeps: assert property (o_irq && take_wr && i_avs_address == 8'hB6
    && i_avs_writedata == 16'h0000 |=> o_irq [*2]) else $error("zero write cleared");
  cover property ($rose(o_irq));
  cover property (i_avs_read && !o_avs_waitrequest && i_avs_address == 8'hBC);
  cover property (take_wr && i_avs_address == 8'hB6);
endmodule : hrx_readout_checker
bind hrx_readout hrx_readout_checker hrx_readout_checker_i (.i_ref_clk(i_ref_clk),
  .i_rstn(i_rstn), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_rx_write(i_rx_write),
  .i_rx_byte(i_rx_byte), .i_rx_status(i_rx_status), .o_irq(o_irq));

/* verification/hrx_host_model.sv */
// Host processor model driving the register port
`timescale 1ns/1ns
module hrx_host_model (
  input wire logic i_ref_clk,
  input wire logic i_waitrequest,
  output logic [7:0] o_address = 8'h00,
  output logic o_read = 1'b0,
  output logic o_write = 1'b0,
  output logic [15:0] o_writedata = 16'h0000,
  output logic [1:0] o_byteenable = 2'h3
);
  // word reads take status with data
  // latched bits cleared by writing ones
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
      input logic [1:0] be);
    o_address <= a;
    o_writedata <= d;
    o_byteenable <= be;
    o_read <= !w;
    o_write <= w;
    @(posedge i_ref_clk);
    while (i_waitrequest !== 1'b0) @(posedge i_ref_clk);
    o_read <= 1'b0;
    o_write <= 1'b0;
    // Gap edge so a following request never re-drives in the same step
    @(posedge i_ref_clk);
  endtask : xfer
endmodule : hrx_host_model

/* verification/hrx_readout_bench.sv */
// Self-checking bench for the receive FIFO readout
`timescale 1ns/1ns
module hrx_readout_bench;
  import hrx_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rd, wr, wq, irq;
  logic rx_wr = 1'b0;
  logic [1:0] be;
  logic [7:0] adr, b;
  logic [7:0] rx_b = 8'h00;
  logic [15:0] wd, rdata;
  hrx_pkt_status_t rx_s = HRX_PS_MIDDLE;
  hrx_pkt_status_t s;
  int num_errors = 0, compares = 0, seed = 28489, cyc = 0;
  logic [15:0] exp_q[$], msk_q[$];
  logic [7:0] fb[$];
  hrx_pkt_status_t fs[$];
  always #4 clk = ~clk;
  // Small depth so full and overflow are reached quickly
  hrx_readout #(.DEPTH(16)) hrx_readout_i (.i_ref_clk(clk), .i_rstn(rstn),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wq),
    .i_rx_write(rx_wr), .i_rx_byte(rx_b), .i_rx_status(rx_s), .o_irq(irq));
  hrx_host_model hrx_host_model_i (.i_ref_clk(clk), .i_waitrequest(wq), .o_address(adr),
    .o_read(rd), .o_write(wr), .o_writedata(wd), .o_byteenable(be));
  task automatic fail(input string m);
    num_errors++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : fail
  task automatic close_out;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m,
      input logic [1:0] bs = 2'h3);
    exp_q.push_back(e);
    msk_q.push_back(m);
    hrx_host_model_i.xfer(1'b0, a, 16'h0000, bs);
  endtask : rd_chk
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    hrx_host_model_i.xfer(1'b1, a, d, 2'h3);
  endtask : wr_reg
  task automatic push(input int n, input hrx_pkt_status_t s0, input bit all);
    for (int k = 0; k < n; k++) begin
      b = 8'($random(seed));
      s = all ? hrx_pkt_status_t'(3'(k)) : (k == 0 ? s0 : HRX_PS_MIDDLE);
      rx_wr <= 1'b1;
      rx_b <= b;
      rx_s <= s;
      fb.push_back(b);
      fs.push_back(s);
      @(posedge clk);
    end
    rx_wr <= 1'b0;
    @(posedge clk);
  endtask : push
  task automatic irq_is(input logic e);
    repeat (2) @(negedge clk);
    compares++;
    if (irq !== e) fail("irq level");
    @(posedge clk);
  endtask : irq_is
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      fail("timeout");
      close_out();
    end
    if (rd && wq === 1'b0) begin
      compares++;
      if ((rdata & msk_q[0]) !== exp_q[0]) fail($sformatf("%h got %h", adr, rdata));
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd_chk(8'hB0, 16'h0800, 16'hFFFF);
    rd_chk(8'hB4, 16'h0002, 16'hFFFF);
    rd_chk(8'hB8, 16'h0000, 16'hFFFF);
    rd_chk(8'hB2, 16'h0000, 16'hFFFF);
    rd_chk(8'hBC, 16'h0000, 16'h0001);
    $display("test reset done");
    wr_reg(8'hB0, 16'h0100);
    wr_reg(8'hB8, 16'h009D);
    wr_reg(8'hC0, 16'h0002);
    irq_is(1'b0);
    push(7, HRX_PS_START, 1'b0);
    rd_chk(8'hB4, 16'h0000, 16'hFFFF);
    irq_is(1'b1);
    wr_reg(8'hB6, 16'h0000);
    rd_chk(8'hB6, 16'h0008, 16'hFFFF);
    wr_reg(8'hB6, 16'h0008);
    irq_is(1'b0);
    push(1, HRX_PS_MIDDLE, 1'b0);
    rd_chk(8'hB4, 16'h0001, 16'hFFFF);
    rd_chk(8'hB6, 16'h0001, 16'hFFFF);
    push(8, HRX_PS_MIDDLE, 1'b1);
    rd_chk(8'hB4, 16'h0005, 16'hFFFF);
    rd_chk(8'hB6, 16'h001D, 16'hFFFF);
    push(1, HRX_PS_MIDDLE, 1'b0);
    void'(fb.pop_back());
    void'(fs.pop_back());
    rd_chk(8'hB6, 16'h009D, 16'hFFFF);
    wr_reg(8'hB6, 16'h009D);
    rd_chk(8'hB6, 16'h0000, 16'hFFFF);
    irq_is(1'b0);
    $display("test fill done");
    for (int i = 0; i < 16; i++) begin
      b = fb.pop_front();
      s = fs.pop_front();
      if (i == 3) rd_chk(8'hBC, {8'h00, 4'h0, s, 1'b1}, 16'h00FF, 2'h1);
      rd_chk(8'hBC, {b, 4'h0, s, 1'b1}, 16'hFFFF);
    end
    rd_chk(8'hBC, 16'h0000, 16'h0001);
    rd_chk(8'hB4, 16'h0002, 16'hFFFF);
    $display("test drain done");
    wr_reg(8'hB0, 16'h0108);
    push(1, HRX_PS_START, 1'b0);
    irq_is(1'b1);
    wr_reg(8'hC0, 16'h0000);
    irq_is(1'b0);
    wr_reg(8'hC0, 16'h0002);
    irq_is(1'b1);
    wr_reg(8'hB8, 16'h0000);
    irq_is(1'b0);
    b = fb.pop_front();
    b = {<<{b}};
    rd_chk(8'hBC, {b, 4'h0, HRX_PS_START, 1'b1}, 16'hFFFF);
    $display("test reorder done");
    close_out();
  end
endmodule : hrx_readout_bench
